// >>> include/hmbx_consts.svh
// Register indices, field positions and reset values of the host mailbox
`ifndef HMBX_CONSTS_SVH
`define HMBX_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define HMBX_IDX_RD_PTR   4'h0
`define HMBX_IDX_WR_PTR   4'h1
`define HMBX_IDX_DATA     4'h2
`define HMBX_IDX_HOST_MSG 4'h3
`define HMBX_IDX_DEV_MSG  4'h4
`define HMBX_IDX_CTRL_LO  4'h5
`define HMBX_IDX_CTRL_HI  4'h6
`define HMBX_IDX_IRQ      4'h7
`define HMBX_IDX_SOFT_RST 4'h8

// Field positions
`define HMBX_BIT_HOST_ACK  0
`define HMBX_BIT_DEV_ACK   0
`define HMBX_BIT_PENDING   2
`define HMBX_BIT_MASK      2
`define HMBX_BIT_SOFT_RST  0

// Reset values
`define HMBX_RST_MASK     1'b1
`define HMBX_RST_PENDING  1'b0
`define HMBX_RST_SOFT     1'b0
`define HMBX_RST_FLAG     1'b0
`define HMBX_RST_BYTE     8'h00

// Soft reset hold time the host must respect, and the cycles it spans
`define HMBX_SOFT_RST_MS     2
`define HMBX_CLK_KHZ         100000
`define HMBX_SOFT_RST_CYCLES (`HMBX_SOFT_RST_MS * `HMBX_CLK_KHZ)

`endif

// >>> include/hmbx_pkg.sv
// Types and address decode shared by the host mailbox files
package hmbx_pkg;

    typedef logic [7:0] hmbx_byte_t;

    typedef struct packed {
        logic       phase;
        hmbx_byte_t rdata;
        hmbx_byte_t rd_ptr;
        hmbx_byte_t wr_ptr;
        hmbx_byte_t host_desc;
        hmbx_byte_t host_ctrl_hi;
        hmbx_byte_t host_ctrl_lo;
        hmbx_byte_t dev_desc;
        hmbx_byte_t dev_ctrl_hi;
        hmbx_byte_t dev_ctrl_lo;
        logic       host_ack;
        logic       soft_rst;
    } hmbx_regs_t;

    typedef struct packed {
        logic pending;
        logic mask;
    } hmbx_irq_t;

    typedef struct packed {
        hmbx_byte_t c_rdata;
    } hmbx_ram_t;

    function automatic logic [3:0] hmbx_reg_idx(input logic [5:0] addr);
        return addr[5:2];
    endfunction

endpackage

// >>> verilog/hmbx_mailbox_ram.sv
// Byte-wide mailbox store shared by the host port and the device core
module hmbx_mailbox_ram #(
    parameter int AW = 8
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_h_we,
    input  wire logic [AW-1:0]       i_h_addr,
    input  wire hmbx_pkg::hmbx_byte_t i_h_wdata,
    output hmbx_pkg::hmbx_byte_t     o_h_rdata,
    input  wire logic                i_c_we,
    input  wire logic [AW-1:0]       i_c_addr,
    input  wire hmbx_pkg::hmbx_byte_t i_c_wdata,
    output hmbx_pkg::hmbx_byte_t     o_c_rdata
);
    import hmbx_pkg::*;
    `include "hmbx_consts.svh"

    hmbx_byte_t mem [2**AW];
    hmbx_ram_t  q;
    hmbx_ram_t  d;

    always_comb begin
        d = q;
        d.c_rdata = mem[i_c_addr];
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q.c_rdata <= `HMBX_RST_BYTE;
        end else begin
            q <= d;
        end
    end

    // Host write placed last: it wins a same-address collision with the core
    always_ff @(posedge i_sys_clk) begin
        if (i_c_we) begin
            mem[i_c_addr] <= i_c_wdata;
        end
        if (i_h_we) begin
            mem[i_h_addr] <= i_h_wdata;
        end
    end

    assign o_h_rdata = mem[i_h_addr];
    assign o_c_rdata = q.c_rdata;
endmodule

// >>> verilog/hmbx_irq_ctrl.sv
// Pending interrupt flag, enable mask and the gated interrupt line
module hmbx_irq_ctrl (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_soft_rst,
    input  wire logic i_set,
    input  wire logic i_clr,
    input  wire logic i_mask_we,
    input  wire logic i_mask_val,
    output logic      o_pending,
    output logic      o_mask,
    output logic      o_irq
);
    import hmbx_pkg::*;
    `include "hmbx_consts.svh"

    hmbx_irq_t q;
    hmbx_irq_t d;

    always_comb begin
        d = q;
        if (i_mask_we) begin
            d.mask = i_mask_val;
        end
        if (i_clr) begin
            d.pending = 1'b0;
        end
        // Set after clear so an event in the clearing cycle survives
        if (i_set) begin
            d.pending = 1'b1;
        end
        if (i_soft_rst) begin
            d.pending = `HMBX_RST_PENDING;
            d.mask    = `HMBX_RST_MASK;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q.pending <= `HMBX_RST_PENDING;
            q.mask    <= `HMBX_RST_MASK;
        end else begin
            q <= d;
        end
    end

    assign o_pending = q.pending;
    assign o_mask    = q.mask;
    assign o_irq     = q.pending & q.mask;
endmodule

// >>> verilog/hmbx_host_mailbox.sv
// Host-facing mailbox register block with Avalon-MM slave and device core port

module hmbx_host_mailbox #(
    parameter int MB_AW = 8
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic [5:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    output logic [31:0]               o_avs_readdata,
    output logic                      o_avs_waitrequest,
    output logic                      o_irq,
    output logic                      o_core_reset,
    output logic                      o_host_msg_pending,
    output hmbx_pkg::hmbx_byte_t      o_host_msg_desc,
    output hmbx_pkg::hmbx_byte_t      o_host_ctrl_hi,
    output hmbx_pkg::hmbx_byte_t      o_host_ctrl_lo,
    input  wire logic                 i_core_accept,
    input  wire logic                 i_core_post,
    input  wire hmbx_pkg::hmbx_byte_t i_core_desc,
    input  wire hmbx_pkg::hmbx_byte_t i_core_ctrl_hi,
    input  wire hmbx_pkg::hmbx_byte_t i_core_ctrl_lo,
    output logic                      o_dev_msg_busy,
    input  wire logic [MB_AW-1:0]     i_core_mb_addr,
    input  wire logic                 i_core_mb_we,
    input  wire hmbx_pkg::hmbx_byte_t i_core_mb_wdata,
    output hmbx_pkg::hmbx_byte_t      o_core_mb_rdata
);
    import hmbx_pkg::*;
    `include "hmbx_consts.svh"

    hmbx_regs_t  q;
    hmbx_regs_t  d;
    logic        req;
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic [3:0]  idx;
    hmbx_byte_t  wbyte;
    hmbx_byte_t  rd_mux;
    hmbx_byte_t  mb_host_rdata;
    logic        mb_host_we;
    logic        pending;
    logic        mask;
    logic        dev_ack_clr;
    logic        post_ok;
    logic        mask_we;

    // Bus handshake: one wait cycle to register read data, answer in the next
    assign req    = i_avs_read | i_avs_write;
    assign acc    = req & q.phase;
    assign idx    = hmbx_reg_idx(i_avs_address);
    assign wbyte  = i_avs_writedata[7:0];
    // Data lives in lane 0, so a write without that lane is answered and dropped
    assign wr_acc = acc & i_avs_write & i_avs_byteenable[0];
    assign rd_acc = acc & i_avs_read;

    assign o_avs_waitrequest = req & ~q.phase;
    assign o_avs_readdata    = {24'h00_0000, q.rdata};

    assign mb_host_we  = wr_acc & (idx == `HMBX_IDX_DATA) & ~q.soft_rst;
    assign dev_ack_clr = wr_acc & (idx == `HMBX_IDX_DEV_MSG) & ~wbyte[`HMBX_BIT_DEV_ACK];
    assign mask_we     = wr_acc & (idx == `HMBX_IDX_IRQ);
    // A post arriving as the host releases the previous message is still taken
    assign post_ok     = i_core_post & ~q.soft_rst & (~pending | dev_ack_clr);

    // Read side of the map; the host pointer picks its own mailbox byte
    always_comb begin
        rd_mux = `HMBX_RST_BYTE;
        case (idx)
            `HMBX_IDX_RD_PTR: begin
                rd_mux = q.rd_ptr;
            end
            `HMBX_IDX_WR_PTR: begin
                rd_mux = q.wr_ptr;
            end
            `HMBX_IDX_DATA: begin
                rd_mux = mb_host_rdata;
            end
            `HMBX_IDX_HOST_MSG: begin
                rd_mux[`HMBX_BIT_HOST_ACK] = q.host_ack;
            end
            `HMBX_IDX_DEV_MSG: begin
                rd_mux = q.dev_desc;
            end
            `HMBX_IDX_CTRL_LO: begin
                rd_mux = q.dev_ctrl_lo;
            end
            `HMBX_IDX_CTRL_HI: begin
                rd_mux = q.dev_ctrl_hi;
            end
            `HMBX_IDX_IRQ: begin
                rd_mux[`HMBX_BIT_PENDING] = pending;
            end
            `HMBX_IDX_SOFT_RST: begin
                rd_mux[`HMBX_BIT_SOFT_RST] = q.soft_rst;
            end
            default: begin
                rd_mux = `HMBX_RST_BYTE;
            end
        endcase
    end

    always_comb begin
        d = q;
        d.phase = req & ~q.phase;
        if (req & ~q.phase) begin
            d.rdata = rd_mux;
        end

        if (wr_acc && idx == `HMBX_IDX_SOFT_RST) begin
            d.soft_rst = wbyte[`HMBX_BIT_SOFT_RST];
        end

        if (wr_acc && idx == `HMBX_IDX_RD_PTR) begin
            d.rd_ptr = wbyte;
        end
        if (wr_acc && idx == `HMBX_IDX_WR_PTR) begin
            d.wr_ptr = wbyte;
        end
        if (rd_acc && idx == `HMBX_IDX_DATA) begin
            d.rd_ptr = q.rd_ptr + 8'h01;
        end
        if (mb_host_we) begin
            d.wr_ptr = q.wr_ptr + 8'h01;
        end

        if (wr_acc && idx == `HMBX_IDX_CTRL_LO) begin
            d.host_ctrl_lo = wbyte;
        end
        if (wr_acc && idx == `HMBX_IDX_CTRL_HI) begin
            d.host_ctrl_hi = wbyte;
        end

        if (i_core_accept) begin
            d.host_ack = 1'b0;
        end
        if (wr_acc && idx == `HMBX_IDX_HOST_MSG) begin
            d.host_desc = wbyte;
            d.host_ack  = 1'b1;
        end

        if (post_ok) begin
            d.dev_desc    = i_core_desc;
            d.dev_ctrl_hi = i_core_ctrl_hi;
            d.dev_ctrl_lo = i_core_ctrl_lo;
        end

        if (q.soft_rst) begin
            d.rd_ptr      = `HMBX_RST_BYTE;
            d.wr_ptr      = `HMBX_RST_BYTE;
            d.host_desc   = `HMBX_RST_BYTE;
            d.host_ctrl_hi = `HMBX_RST_BYTE;
            d.host_ctrl_lo = `HMBX_RST_BYTE;
            d.dev_desc    = `HMBX_RST_BYTE;
            d.dev_ctrl_hi = `HMBX_RST_BYTE;
            d.dev_ctrl_lo = `HMBX_RST_BYTE;
            d.host_ack    = `HMBX_RST_FLAG;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q.phase        <= 1'b0;
            q.rdata        <= `HMBX_RST_BYTE;
            q.rd_ptr       <= `HMBX_RST_BYTE;
            q.wr_ptr       <= `HMBX_RST_BYTE;
            q.host_desc    <= `HMBX_RST_BYTE;
            q.host_ctrl_hi <= `HMBX_RST_BYTE;
            q.host_ctrl_lo <= `HMBX_RST_BYTE;
            q.dev_desc     <= `HMBX_RST_BYTE;
            q.dev_ctrl_hi  <= `HMBX_RST_BYTE;
            q.dev_ctrl_lo  <= `HMBX_RST_BYTE;
            q.host_ack     <= `HMBX_RST_FLAG;
            q.soft_rst     <= `HMBX_RST_SOFT;
        end else begin
            q <= d;
        end
    end

    hmbx_mailbox_ram #(
        .AW (MB_AW)
    ) u_ram (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_h_we    (mb_host_we),
        .i_h_addr  (mb_host_we ? q.wr_ptr[MB_AW-1:0] : q.rd_ptr[MB_AW-1:0]),
        .i_h_wdata (wbyte),
        .o_h_rdata (mb_host_rdata),
        .i_c_we    (i_core_mb_we & ~q.soft_rst),
        .i_c_addr  (i_core_mb_addr),
        .i_c_wdata (i_core_mb_wdata),
        .o_c_rdata (o_core_mb_rdata)
    );

    hmbx_irq_ctrl u_irq (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_soft_rst (q.soft_rst),
        .i_set      (post_ok),
        .i_clr      (dev_ack_clr),
        .i_mask_we  (mask_we),
        .i_mask_val (wbyte[`HMBX_BIT_MASK]),
        .o_pending  (pending),
        .o_mask     (mask),
        .o_irq      (o_irq)
    );

    assign o_core_reset       = q.soft_rst;
    assign o_host_msg_pending = q.host_ack;
    assign o_host_msg_desc    = q.host_desc;
    assign o_host_ctrl_hi     = q.host_ctrl_hi;
    assign o_host_ctrl_lo     = q.host_ctrl_lo;
    assign o_dev_msg_busy     = pending;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Every request is answered in the second cycle at the latest
    bus_answer_a: assert property (
        req |-> ##[0:1] !o_avs_waitrequest
    ) else $error("request not answered within two cycles");

    // The releasing write itself is left out: the bit drops at the edge that follows it
    soft_reset_hold_a: assert property (
        (q.soft_rst && !(wr_acc && idx == `HMBX_IDX_SOFT_RST))
            |=> (!o_host_msg_pending && !pending && o_core_reset)
    ) else $error("device state not held in soft reset");

    irq_masked_off_a: assert property (
        !mask |-> !o_irq
    ) else $error("interrupt driven while masked");

    irq_unmask_shows_a: assert property (
        (pending && !mask && mask_we && wbyte[`HMBX_BIT_MASK] && !q.soft_rst
            && !dev_ack_clr) |=> o_irq
    ) else $error("pending interrupt lost across unmask");

    status_read_a: assert property (
        (req && !q.phase && idx == `HMBX_IDX_IRQ && !q.soft_rst)
            |=> o_avs_readdata[`HMBX_BIT_PENDING] == $past(pending)
    ) else $error("status bit does not follow pending");

    host_handover_a: assert property (
        (wr_acc && idx == `HMBX_IDX_HOST_MSG && !q.soft_rst)
            |=> o_host_msg_pending && o_host_msg_desc == $past(wbyte)
    ) else $error("descriptor write did not raise host acknowledge");

    core_accept_a: assert property (
        (i_core_accept && !(wr_acc && idx == `HMBX_IDX_HOST_MSG))
            |=> !o_host_msg_pending
    ) else $error("host acknowledge not cleared by core accept");

    wr_ptr_step_a: assert property (
        mb_host_we |=> q.wr_ptr == $past(q.wr_ptr) + 8'h01
    ) else $error("write pointer did not advance by one");

    rd_ptr_step_a: assert property (
        (rd_acc && idx == `HMBX_IDX_DATA && !q.soft_rst)
            |=> q.rd_ptr == $past(q.rd_ptr) + 8'h01
    ) else $error("read pointer did not advance by one");

    ptr_readback_a: assert property (
        (rd_acc && idx == `HMBX_IDX_RD_PTR) |-> o_avs_readdata[7:0] == $past(q.rd_ptr)
    ) else $error("read pointer readback wrong");

    post_latch_a: assert property (
        post_ok |=> (q.dev_desc == $past(i_core_desc) && pending)
    ) else $error("posted device message not latched");

    irq_exact_a: assert property (
        (pending && mask) |-> o_irq
    ) else $error("interrupt inactive while pending and enabled");

endmodule

// >>> tb/hmbx_core_model.sv
// Behavioural device core facing the mailbox block's core port
module hmbx_core_model (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_host_msg_pending,
    input  wire logic                 i_slow,
    input  wire logic                 i_post_go,
    input  wire hmbx_pkg::hmbx_byte_t i_post_desc,
    input  wire hmbx_pkg::hmbx_byte_t i_post_len,
    output logic                      o_core_accept,
    output logic                      o_core_post,
    output hmbx_pkg::hmbx_byte_t      o_core_desc,
    output hmbx_pkg::hmbx_byte_t      o_core_ctrl_hi,
    output hmbx_pkg::hmbx_byte_t      o_core_ctrl_lo,
    output logic [7:0]                o_core_mb_addr,
    output logic                      o_core_mb_we,
    output hmbx_pkg::hmbx_byte_t      o_core_mb_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import hmbx_pkg::*;
    int wait_cnt = 0;
    initial begin
        {o_core_accept, o_core_post, o_core_mb_we} = 3'h0;
        {o_core_desc, o_core_ctrl_hi, o_core_ctrl_lo} = 24'h00_0000;
        {o_core_mb_addr, o_core_mb_wdata} = 16'h0000;
    end
    // accept when ready, slow or prompt
    always @(posedge i_sys_clk) begin
        o_core_accept <= 1'b0;
        if (i_host_msg_pending && !o_core_accept) begin
            wait_cnt = wait_cnt + 1;
            if (wait_cnt >= (i_slow ? 40 : 2)) begin
                o_core_accept <= 1'b1;
                wait_cnt = 0;
            end
        end
    end
    // fill mailbox then post descriptor, control word and count
    always begin
        @(posedge i_sys_clk);
        if (i_post_go) begin
            for (int k = 0; k < i_post_len; k++) begin
                o_core_mb_addr  <= 8'(k);
                o_core_mb_we    <= 1'b1;
                o_core_mb_wdata <= i_post_desc + 8'(k);
                @(posedge i_sys_clk);
            end
            o_core_mb_we    <= 1'b0;
            o_core_mb_wdata <= ~o_core_mb_wdata;
            o_core_post     <= 1'b1;
            o_core_desc     <= i_post_desc;
            o_core_ctrl_hi  <= ~i_post_desc;
            o_core_ctrl_lo  <= i_post_len;
            @(posedge i_sys_clk);
            // Released descriptor and count lines show the inverse so a late sample cannot pass
            o_core_post    <= 1'b0;
            o_core_desc    <= ~i_post_desc;
            o_core_ctrl_lo <= ~i_post_len;
        end
    end
endmodule

// >>> tb/host_mailbox_interface_tb_top.sv
// Self-checking bench for the host mailbox register block
`include "hmbx_consts.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module host_mailbox_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hmbx_pkg::*;
    localparam logic [3:0] ix_rp = `HMBX_IDX_RD_PTR;
    localparam logic [3:0] ix_wp = `HMBX_IDX_WR_PTR;
    localparam logic [3:0] ix_dp = `HMBX_IDX_DATA;
    localparam logic [3:0] ix_hm = `HMBX_IDX_HOST_MSG;
    localparam logic [3:0] ix_dm = `HMBX_IDX_DEV_MSG;
    localparam logic [3:0] ix_cl = `HMBX_IDX_CTRL_LO;
    localparam logic [3:0] ix_ch = `HMBX_IDX_CTRL_HI;
    localparam logic [3:0] ix_iq = `HMBX_IDX_IRQ;
    localparam logic [3:0] ix_sr = `HMBX_IDX_SOFT_RST;
    logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, core_reset;
    logic        host_pend, core_accept, core_post, dev_busy, mb_we, slow, post_go;
    logic [5:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  mb_addr;
    hmbx_byte_t  host_desc, host_hi, host_lo, core_desc, core_hi, core_lo;
    hmbx_byte_t  mb_wdata, mb_rdata, post_desc, post_len, x, mbx [8];
    int          error_cnt, checks_done, seed, n, k;

    hmbx_host_mailbox dut (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_irq(irq),
        .o_core_reset(core_reset), .o_host_msg_pending(host_pend),
        .o_host_msg_desc(host_desc), .o_host_ctrl_hi(host_hi), .o_host_ctrl_lo(host_lo),
        .i_core_accept(core_accept), .i_core_post(core_post), .i_core_desc(core_desc),
        .i_core_ctrl_hi(core_hi), .i_core_ctrl_lo(core_lo), .o_dev_msg_busy(dev_busy),
        .i_core_mb_addr(mb_addr), .i_core_mb_we(mb_we), .i_core_mb_wdata(mb_wdata),
        .o_core_mb_rdata(mb_rdata));
    hmbx_core_model u_core (.i_sys_clk(sys_clk), .i_host_msg_pending(host_pend),
        .i_slow(slow), .i_post_go(post_go), .i_post_desc(post_desc), .i_post_len(post_len),
        .o_core_accept(core_accept), .o_core_post(core_post), .o_core_desc(core_desc),
        .o_core_ctrl_hi(core_hi), .o_core_ctrl_lo(core_lo), .o_core_mb_addr(mb_addr),
        .o_core_mb_we(mb_we), .o_core_mb_wdata(mb_wdata));

    always #5 sys_clk = ~sys_clk;

    function automatic hmbx_byte_t core_byte(input hmbx_byte_t d, input int i);
        return d + 8'(i);
    endfunction

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] ix, input hmbx_byte_t wd,
                       input logic [3:0] be, output hmbx_byte_t d);
        int t;
        t = 0;
        @(posedge sys_clk);
        avs_address    <= {ix, 2'b00};
        avs_read       <= !w;
        avs_write      <= w;
        avs_writedata  <= {24'h00_0000, wd};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        `CHK(avs_waitrequest, 1'b0)
        d = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] ix, input hmbx_byte_t wd);
        bus(1'b1, ix, wd, 4'hF, x);
    endtask
    task automatic rdc(input logic [3:0] ix, input hmbx_byte_t e);
        bus(1'b0, ix, 8'h00, 4'hF, x);
        `CHK(x, e)
    endtask
    task automatic await(input logic host, input logic v);
        int t;
        t = 0;
        while ((host ? host_pend : dev_busy) !== v && t < 300) begin
            @(negedge sys_clk);
            t++;
        end
        `CHK(host ? host_pend : dev_busy, v)
    endtask
    task automatic post(input hmbx_byte_t d, input hmbx_byte_t l);
        post_desc <= d;
        post_len  <= l;
        post_go   <= 1'b1;
        @(posedge sys_clk);
        post_go <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #300_000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        {sys_clk, sys_rst, avs_read, avs_write, slow, post_go} = 6'h10;
        {avs_address, avs_byteenable, avs_writedata} = 42'h0;
        {post_desc, post_len, error_cnt, checks_done} = 0;
        seed = 32'he1d6;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc(ix_rp, 8'h00);
        rdc(ix_wp, 8'h00);
        rdc(ix_iq, 8'h00);
        rdc(ix_sr, 8'h00);
        rdc(ix_hm, 8'h00);
        `CHK(irq, 1'b0)
        wr(4'hC, 8'hA5);
        rdc(4'hC, 8'h00);
        // Sequential stream, then one random-access read
        repeat (4) begin
            n = 1 + ($unsigned($random(seed)) % 8);
            wr(ix_wp, 8'h00);
            for (k = 0; k < n; k++) begin
                mbx[k] = 8'($random(seed));
                wr(ix_dp, mbx[k]);
            end
            rdc(ix_wp, 8'(n));
            wr(ix_rp, 8'h00);
            for (k = 0; k < n; k++) rdc(ix_dp, mbx[k]);
            rdc(ix_rp, 8'(n));
            k = $unsigned($random(seed)) % n;
            wr(ix_rp, 8'(k));
            rdc(ix_dp, mbx[k]);
        end
        // Highway setup for channel one then two, descriptor written last;
        // parameter byte 0 is the timeslot, kept apart; slow then prompt core
        for (n = 0; n < 2; n++) begin
            slow <= (n == 0);
            wr(ix_wp, 8'h00);
            for (k = 0; k < 5; k++) begin
                mbx[k] = (k == 0) ? 8'(n * 2) : 8'($random(seed));
                wr(ix_dp, mbx[k]);
            end
            wr(ix_ch, 8'h83);
            wr(ix_cl, 8'h05);
            wr(ix_hm, (n == 0) ? 8'h67 : 8'hA7);
            @(negedge sys_clk);
            `CHK(host_pend, 1'b1)
            `CHK(host_desc, (n == 0) ? 8'h67 : 8'hA7)
            `CHK(host_hi, 8'h83)
            `CHK(host_lo, 8'h05)
            if (n == 0) rdc(ix_hm, 8'h01);
            await(1'b1, 1'b0);
            rdc(ix_hm, 8'h00);
            wr(ix_rp, 8'h00);
            for (k = 0; k < 5; k++) rdc(ix_dp, mbx[k]);
        end
        bus(1'b1, ix_cl, 8'hFF, 4'h0, x);
        @(negedge sys_clk);
        `CHK(host_lo, 8'h05)
        // Device messages arriving while the interrupt is masked
        repeat (3) begin
            wr(ix_iq, 8'h00);
            post(8'($random(seed)), 8'(1 + ($unsigned($random(seed)) % 6)));
            await(1'b0, 1'b1);
            repeat (3) @(negedge sys_clk);
            `CHK(irq, 1'b0)
            `CHK(mb_rdata, core_byte(post_desc, post_len - 8'h01))
            rdc(ix_iq, 8'h04);
            rdc(ix_dm, post_desc);
            rdc(ix_ch, ~post_desc);
            rdc(ix_cl, post_len);
            wr(ix_rp, 8'h00);
            for (k = 0; k < post_len; k++) rdc(ix_dp, core_byte(post_desc, k));
            wr(ix_iq, 8'h04);
            @(negedge sys_clk);
            `CHK(irq, 1'b1)
            wr(ix_dm, 8'h01);
            `CHK(dev_busy, 1'b1)
            wr(ix_dm, 8'h00);
            @(negedge sys_clk);
            `CHK(dev_busy, 1'b0)
            `CHK(irq, 1'b0)
            rdc(ix_iq, 8'h00);
        end
        // Soft reset holds the core and drops posts until written back to 0
        wr(ix_wp, 8'h33);
        wr(ix_sr, 8'h01); // held briefly here; the block itself does not time the hold
        @(negedge sys_clk);
        `CHK(core_reset, 1'b1)
        rdc(ix_sr, 8'h01);
        rdc(ix_wp, 8'h00);
        post(8'h5A, 8'h02);
        repeat (10) @(negedge sys_clk);
        `CHK(dev_busy, 1'b0)
        wr(ix_sr, 8'h00);
        @(negedge sys_clk);
        `CHK(core_reset, 1'b0)
        post(8'h3C, 8'h01);
        await(1'b0, 1'b1);
        `CHK(irq, 1'b1)
        wr(ix_dm, 8'h00);
        end_of_test();
    end
endmodule
